//--- srg_host_model.sv
// host and push-button model on the far side of the reset generator
`timescale 1ns/100ps

// ==========================================================
// button model
module srg_host_model
    import srg_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire srg_pkg::srg_outputs_t reset_out,
    output logic                      manual_reset_n
);
    logic host_running;

    // button open: the pin's pull-up holds it high
    initial manual_reset_n = 1'b1;

    // holds the pin low for n edges; short holds model contact bounce
    task automatic press(input int n);
        @(posedge clk_sys);
        manual_reset_n <= 1'b0;
        repeat (n) @(posedge clk_sys);
        manual_reset_n <= 1'b1;
    endtask

    // host runs only while both reset lines read inactive
    always @(posedge clk_sys)
        host_running <= (reset_out.rst_hi === 1'b0) && (reset_out.rst_lo_n === 1'b1);
endmodule

//--- srg_pkg.sv
// shared constants and types of the supply reset generator
package srg_pkg;

    localparam int CLK_MHZ = 25;

    // reset hold options, typical figures in microseconds
    localparam int HOLD_OPT0_US = 1400;
    localparam int HOLD_OPT1_US = 30000;
    localparam int HOLD_OPT2_US = 200000;
    localparam int HOLD_OPT3_US = 1600000;
    localparam int HOLD_OPT0_CYC = HOLD_OPT0_US * CLK_MHZ;
    localparam int HOLD_OPT1_CYC = HOLD_OPT1_US * CLK_MHZ;
    localparam int HOLD_OPT2_CYC = HOLD_OPT2_US * CLK_MHZ;
    localparam int HOLD_OPT3_CYC = HOLD_OPT3_US * CLK_MHZ;
    localparam int HOLD_SEL_RST = 2;
    localparam int HOLD_W = 26;

    // manual reset input: glitch floor and request delay, in ns
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int GLITCH_NS = 100;
    localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int MANUAL_DELAY_NS = 1000;
    localparam int MANUAL_DELAY_CYC = (MANUAL_DELAY_NS + CLK_NS - 1) / CLK_NS;

    // undervoltage persistence, shallow and deep excursions, in ns
    localparam int UV_SHALLOW_NS = 10000;
    localparam int UV_DEEP_NS = 1000;
    localparam int UV_SHALLOW_CYC = (UV_SHALLOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int UV_DEEP_CYC = (UV_DEEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 10;

    // reset values
    localparam logic UV_RST = 1'b1;
    localparam logic MR_PIN_RST = 1'b1;
    localparam logic CMP_RST = 1'b0;

    typedef enum logic [1:0] {ST_ACTIVE, ST_HOLD, ST_RELEASED} srg_state_t;

    typedef struct packed {
        logic od_low;      // open-drain data, always low
        logic od_oe;       // drives the active-low line low
        logic pullup_en;   // internal pull-up connected
        logic rst_hi;      // push-pull active-high reset
        logic rst_lo_n;    // push-pull active-low reset
    } srg_outputs_t;

endpackage

//--- srg_top.sv
// supply reset generator: undervoltage, manual and watchdog reset with delay hold
`timescale 1ns/100ps

// ==========================================================
// pin synchroniser, three stages, change taken when 2 and 3 agree
module srg_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level
);
    logic [2:0] stg_q;
    logic [2:0] stg_d;
    logic       lvl_q;
    logic       lvl_d;

    assign level = lvl_q;

    always_comb
    begin
        stg_d = {stg_q[1:0], pin};
        lvl_d = (stg_q[1] == stg_q[2]) ? stg_q[2] : lvl_q;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            stg_q <= {3{RST_VAL}};
            lvl_q <= RST_VAL;
        end
        else
        begin
            stg_q <= stg_d;
            lvl_q <= lvl_d;
        end
    end
endmodule

// ==========================================================
module srg_top
    import srg_pkg::*;
#(
    parameter int HOLD_SEL = HOLD_SEL_RST,
    parameter int HOLD0_CYC = HOLD_OPT0_CYC,
    parameter int HOLD1_CYC = HOLD_OPT1_CYC,
    parameter int HOLD2_CYC = HOLD_OPT2_CYC,
    parameter int HOLD3_CYC = HOLD_OPT3_CYC
) (
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          supply_below_trip,
    input  wire logic          supply_above_release,
    input  wire logic          supply_deep_under,
    input  wire logic          manual_reset_n,
    input  wire logic          watchdog_timeout_req,
    output srg_pkg::srg_outputs_t reset_out
);
    import srg_pkg::*;

    logic below_s;
    logic above_s;
    logic deep_s;
    logic mr_s;

    srg_sync #(.RST_VAL(CMP_RST)) u_sync_below (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (supply_below_trip),
        .level   (below_s)
    );
    srg_sync #(.RST_VAL(CMP_RST)) u_sync_above (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (supply_above_release),
        .level   (above_s)
    );
    srg_sync #(.RST_VAL(CMP_RST)) u_sync_deep (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (supply_deep_under),
        .level   (deep_s)
    );
    srg_sync #(.RST_VAL(MR_PIN_RST)) u_sync_mr (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin     (manual_reset_n),
        .level   (mr_s)
    );

    // ==========================================================
    // hold option selection, fixed at build time
    logic [HOLD_W-1:0] hold_cyc;

    always_comb
    begin
        case (HOLD_SEL)
            0:       hold_cyc = HOLD_W'(HOLD0_CYC);
            1:       hold_cyc = HOLD_W'(HOLD1_CYC);
            3:       hold_cyc = HOLD_W'(HOLD3_CYC);
            default: hold_cyc = HOLD_W'(HOLD2_CYC);
        endcase
    end

    // ==========================================================
    // undervoltage detection with persistence and hysteresis
    localparam logic [CNT_W-1:0] UV_SHALLOW_LAST = CNT_W'(UV_SHALLOW_CYC - 1);
    localparam logic [CNT_W-1:0] UV_DEEP_LAST = CNT_W'(UV_DEEP_CYC - 1);

    logic [CNT_W-1:0] uv_cnt_q;
    logic [CNT_W-1:0] uv_cnt_d;
    logic             uv_q;
    logic             uv_d;
    logic             uv_hit;

    always_comb
    begin
        // deeper excursion needs a shorter persistence
        uv_hit = below_s && ((deep_s && uv_cnt_q >= UV_DEEP_LAST)
                 || uv_cnt_q >= UV_SHALLOW_LAST);
        uv_cnt_d = uv_cnt_q;
        if (!below_s)
            uv_cnt_d = '0;
        else if (!uv_hit)
            uv_cnt_d = uv_cnt_q + 1'b1;
        uv_d = uv_q;
        if (uv_hit)
            uv_d = 1'b1;
        else if (above_s)
            uv_d = 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            uv_cnt_q <= '0;
            uv_q     <= UV_RST;
        end
        else
        begin
            uv_cnt_q <= uv_cnt_d;
            uv_q     <= uv_d;
        end
    end

    // ==========================================================
    // manual reset: low must persist the request delay
    localparam logic [CNT_W-1:0] MR_LAST = CNT_W'(MANUAL_DELAY_CYC - 1);

    logic [CNT_W-1:0] mr_cnt_q;
    logic [CNT_W-1:0] mr_cnt_d;
    logic             mr_q;
    logic             mr_d;

    always_comb
    begin
        mr_cnt_d = '0;
        mr_d     = 1'b0;
        // a pulse shorter than the delay never reaches the count end
        if (!mr_s)
        begin
            mr_d     = mr_q || (mr_cnt_q == MR_LAST);
            mr_cnt_d = mr_d ? mr_cnt_q : mr_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mr_cnt_q <= '0;
            mr_q     <= 1'b0;
        end
        else
        begin
            mr_cnt_q <= mr_cnt_d;
            mr_q     <= mr_d;
        end
    end

    // ==========================================================
    // reset sequencer with delay hold
    srg_state_t        state_q;
    srg_state_t        state_d;
    logic [HOLD_W-1:0] hold_cnt_q;
    logic [HOLD_W-1:0] hold_cnt_d;
    srg_outputs_t      out_q;
    srg_outputs_t      out_d;
    logic              src;
    logic              act_d;

    assign src = uv_q || mr_q || watchdog_timeout_req;
    assign reset_out = out_q;

    always_comb
    begin
        state_d    = state_q;
        hold_cnt_d = '0;
        case (state_q)
            ST_ACTIVE:
            begin
                if (!src)
                    state_d = ST_HOLD;
            end
            ST_HOLD:
            begin
                if (src)
                    state_d = ST_ACTIVE;
                else if (hold_cnt_q == hold_cyc - 1'b1)
                    state_d = ST_RELEASED;
                else
                    hold_cnt_d = hold_cnt_q + 1'b1;
            end
            ST_RELEASED:
            begin
                if (src)
                    state_d = ST_ACTIVE;
            end
            default: state_d = ST_ACTIVE;
        endcase
        // outputs follow the next state so they line up with state_q
        act_d           = (state_d != ST_RELEASED);
        out_d.od_low    = 1'b0;
        out_d.od_oe     = act_d;
        out_d.pullup_en = !act_d;
        out_d.rst_hi    = act_d;
        out_d.rst_lo_n  = !act_d;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q    <= ST_ACTIVE;
            hold_cnt_q <= '0;
            out_q      <= '{od_low: 1'b0, od_oe: 1'b1, pullup_en: 1'b0,
                            rst_hi: 1'b1, rst_lo_n: 1'b0};
        end
        else
        begin
            state_q    <= state_d;
            hold_cnt_q <= hold_cnt_d;
            out_q      <= out_d;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_trip_forces_active: assert property (
        uv_hit |-> ##2 out_q.rst_hi && !out_q.rst_lo_n)
        else $error("undervoltage did not assert reset");

    a_hyst_holds_uv: assert property (
        uv_q && !above_s |=> uv_q)
        else $error("undervoltage cleared below release level");

    a_pullup_off_low: assert property (
        out_q.od_oe |-> !out_q.pullup_en && !out_q.od_low)
        else $error("pull-up connected while driving low");

    a_hold_full_time: assert property (
        $fell(out_q.rst_hi) |-> $past(hold_cnt_q) == hold_cyc - 1'b1
                                && $past(state_q) == ST_HOLD)
        else $error("reset released before hold expired");

    a_hold_after_src: assert property (
        state_q == ST_ACTIVE && !src |=> state_q == ST_HOLD && hold_cnt_q == '0)
        else $error("hold did not start from zero");

    a_manual_delay: assert property (
        $rose(mr_q) |-> $past(mr_cnt_q) == MR_LAST && !$past(mr_s))
        else $error("manual reset taken at wrong delay");

    a_manual_glitch: assert property (
        !mr_s ##1 mr_s |=> !mr_q [*3])
        else $error("released manual input kept request");

    a_uv_persist: assert property (
        $rose(uv_q) |-> $past(below_s) && ($past(uv_cnt_q) >= UV_SHALLOW_LAST
                        || ($past(deep_s) && $past(uv_cnt_q) >= UV_DEEP_LAST)))
        else $error("undervoltage taken without persistence");

    a_watchdog_reset: assert property (
        watchdog_timeout_req |=> out_q.rst_hi ##1 out_q.rst_hi)
        else $error("watchdog request did not assert reset");

    a_out_complement: assert property (
        out_q.rst_hi != out_q.rst_lo_n && out_q.rst_hi == out_q.od_oe)
        else $error("reset outputs not complementary");

    a_restart_timer: assert property (
        state_q == ST_HOLD && src |=> state_q == ST_ACTIVE && hold_cnt_q == '0)
        else $error("hold timer not restarted");

    c_release: cover property ($fell(out_q.rst_hi));
    c_manual: cover property ($rose(mr_q) ##[1:1000] $fell(out_q.rst_hi));
    c_watchdog: cover property (state_q == ST_RELEASED && watchdog_timeout_req);
    c_restart: cover property (state_q == ST_HOLD && src);

endmodule

//--- test_supply_reset_generator.sv
// self-checking testbench of the supply reset generator
`timescale 1ns/100ps

// ==========================================================
// bench top
module test_supply_reset_generator;
    import srg_pkg::*;
    localparam int HOLD = 60;
    localparam logic [4:0] ACT = 5'h0a;
    localparam logic [4:0] REL = 5'h05;

    logic         clk_sys;
    logic         rst;
    logic         below;
    logic         above;
    logic         deep;
    logic         wdg;
    logic         manual_reset_n;
    srg_outputs_t reset_out;
    int           fail_count;
    int           tests_run;
    int           cyc;
    int           n;

    // default hold select left alone so the 200 ms slot is the one used
    srg_top #(.HOLD2_CYC(HOLD)) dut (
        .clk_sys              (clk_sys),
        .rst                  (rst),
        .supply_below_trip    (below),
        .supply_above_release (above),
        .supply_deep_under    (deep),
        .manual_reset_n       (manual_reset_n),
        .watchdog_timeout_req (wdg),
        .reset_out            (reset_out)
    );

    srg_host_model host (
        .clk_sys        (clk_sys),
        .reset_out      (reset_out),
        .manual_reset_n (manual_reset_n)
    );

    // ==========================================================
    // clock, reset, timeout
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial
    begin
        rst = 1'b1; below = 1'b1; above = 1'b0; deep = 1'b0; wdg = 1'b0;
        fail_count = 0; tests_run = 0; cyc = 0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_powerup();
        t_undervolt();
        t_manual();
        t_watchdog();
        results();
    end

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fail_count++;
            results();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic tick(input int m);
        repeat (m) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk_out(input logic [4:0] got, input logic [4:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic chk_range(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
            fail_count++;
        end
    endtask

    task automatic wait_rel(output int m);
        m = 0;
        while (reset_out.rst_hi !== 1'b0 && m < 4 * HOLD)
        begin
            tick(1);
            m++;
        end
    endtask

    task automatic hit(input int lim, output int m);
        m = 0;
        while (reset_out.rst_hi !== 1'b1 && m < lim)
        begin
            tick(1);
            m++;
        end
    endtask

    // any glitch of the outputs in the window is kept and reported
    task automatic quiet(input int m);
        logic [4:0] worst;
        worst = REL;
        repeat (m)
        begin
            tick(1);
            if (reset_out !== REL)
                worst = reset_out;
        end
        chk_out(worst, REL);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_powerup();
        tick(40);
        chk_out(reset_out, ACT);
        @(posedge clk_sys);
        below <= 1'b0;
        above <= 1'b1;
        wait_rel(n);
        chk_range(n, HOLD, HOLD + 10);
        chk_out(reset_out, REL);
    endtask

    task automatic t_undervolt();
        @(posedge clk_sys);
        below <= 1'b1;
        above <= 1'b0;
        tick(100);
        @(posedge clk_sys);
        below <= 1'b0;
        above <= 1'b1;
        quiet(300);
        @(posedge clk_sys);
        below <= 1'b1; deep <= 1'b1; above <= 1'b0;
        tick(10);
        @(posedge clk_sys);
        below <= 1'b0; deep <= 1'b0; above <= 1'b1;
        quiet(100);
        @(posedge clk_sys);
        below <= 1'b1; deep <= 1'b1; above <= 1'b0;
        hit(60, n);
        chk_range(n, UV_DEEP_CYC, UV_DEEP_CYC + 8);
        chk_out(reset_out, ACT);
        @(posedge clk_sys);
        below <= 1'b0; deep <= 1'b0;
        tick(50);
        chk_out(reset_out, ACT);
        @(posedge clk_sys);
        above <= 1'b1;
        wait_rel(n);
        chk_range(n, HOLD, HOLD + 10);
        // shallow excursion: only the long persistence may trip it
        @(posedge clk_sys);
        below <= 1'b1;
        above <= 1'b0;
        hit(400, n);
        chk_range(n, UV_SHALLOW_CYC, UV_SHALLOW_CYC + 8);
        @(posedge clk_sys);
        below <= 1'b0;
        above <= 1'b1;
        wait_rel(n);
        chk_range(n, HOLD, HOLD + 10);
    endtask

    task automatic t_manual();
        host.press(2);
        quiet(60);
        host.press(10);
        quiet(60);
        host.press(45);
        #1;
        chk_out(reset_out, ACT);
        chk_out({4'h0, host.host_running}, 5'h00);
        wait_rel(n);
        chk_range(n, HOLD, HOLD + 8);
    endtask

    task automatic t_watchdog();
        @(posedge clk_sys);
        wdg <= 1'b1;
        @(posedge clk_sys);
        wdg <= 1'b0;
        hit(3, n);
        chk_out(reset_out, ACT);
        tick(HOLD / 2);
        @(posedge clk_sys);
        wdg <= 1'b1;
        @(posedge clk_sys);
        wdg <= 1'b0;
        wait_rel(n);
        chk_range(n, HOLD, HOLD + 4);
        quiet(20);
        chk_out({4'h0, host.host_running}, 5'h01);
    endtask

    // ==========================================================
    // verdict
    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
endmodule
